/* File: dv/ddabe_bus_mem.sv */
// Word memory standing in for the memory and I/O controllers.
// Assumes one busAck per beat; slow leaves a gap cycle between beats.
`timescale 1ns/1ps
module ddabe_bus_mem (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Bus from the engine
    input wire logic busReq,
    input wire logic busWrite,
    input wire logic [31:0] busAddr,
    input wire logic [3:0] busBeats,
    input wire logic [31:0] busWdata,
    output logic busAck,
    output logic [31:0] busRdata,
    // Pace select
    input wire logic slow
);
    logic [31:0] mem [0:127];
    logic [3:0] beat;
    logic [31:0] lastRd;
    wire [6:0] idx = busAddr[8:2] + 7'(beat);
    // Read data only with ack, inverted junk otherwise
    assign busRdata = busAck ? mem[idx] : ~lastRd;
    // One ack per beat, never past the burst length
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busAck <= 1'b0;
            beat <= 4'h0;
            lastRd <= 32'h0000_0000;
        end else if (!busReq) begin
            busAck <= 1'b0;
            beat <= 4'h0;
        end else if (busAck) begin
            if (busWrite) mem[idx] <= busWdata;
            else lastRd <= mem[idx];
            beat <= beat + 4'h1;
            busAck <= !slow && (beat + 4'h1 < busBeats);
        end else if (beat < busBeats) begin
            busAck <= 1'b1;
        end
    end
endmodule : ddabe_bus_mem

/* File: dv/tb.sv */
// Self-checking bench for the DMA channel: APB tasks, bus model, monitor.
// Assumes one APB access cycle and word beats on the internal bus.
`timescale 1ns/1ps
module tb
    import ddabe_pkg::*;
;
    localparam int LIMIT = 20000;
    localparam logic [31:0] C8 = 32'(UNIT_8W) << CTL_UNIT_LO;
    localparam logic [31:0] C4B = 32'(UNIT_4B) << CTL_UNIT_LO;
    localparam logic [31:0] C4W = 32'(UNIT_4W) << CTL_UNIT_LO;
    localparam logic [31:0] SM = 32'h1 << CTL_SIZE_MODE;
    localparam logic [31:0] SI = 32'h1 << CTL_SRC_INH;
    localparam logic [31:0] DI = 32'h1 << CTL_DST_INH;
    localparam logic [31:0] RV = 32'h1 << CTL_REVERSE;
    // Stimulus and observed signals
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic fifoHeldByOther = 1'b0;
    logic slow = 1'b0;
    logic pready, pslverr, busReq, busWrite, busAck, fifoHold, reqSeen, holdSeen;
    logic [31:0] prdata, busAddr, busWdata, busRdata;
    logic [2:0] busSize;
    logic [3:0] busBeats;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    int bursts, maxR, maxW, firstR;

    ddabe_engine u_ddabe_engine (
        .sys_clk(sys_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .busReq(busReq), .busWrite(busWrite),
        .busAddr(busAddr), .busSize(busSize), .busBeats(busBeats), .busWdata(busWdata),
        .busAck(busAck), .busRdata(busRdata), .fifoHeldByOther(fifoHeldByOther),
        .fifoHold(fifoHold)
    );
    ddabe_bus_mem u_ddabe_bus_mem (
        .sys_clk(sys_clk), .resetn(resetn), .busReq(busReq), .busWrite(busWrite),
        .busAddr(busAddr), .busBeats(busBeats), .busWdata(busWdata), .busAck(busAck),
        .busRdata(busRdata), .slow(slow)
    );

    always #4 sys_clk = ~sys_clk;

    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            $display("BAD t=%0t timeout", $time);
            complete_run();
        end
    end

    // Burst monitor: line crossing, beat size, largest bursts, buffer hold
    always @(posedge sys_clk) begin
        if (fifoHold === 1'b1) holdSeen = 1'b1;
        if (busReq === 1'b1 && reqSeen !== 1'b1) begin
            bursts++;
            chk({29'h0, busSize}, 32'h4, "beat size");
            chk(32'(busAddr[6:2]) + 32'(busBeats) <= 32, 32'h1, "line crossed");
            if (busWrite) maxW = (busBeats > maxW) ? busBeats : maxW;
            else if (firstR == 0) firstR = busBeats;
            if (!busWrite) maxR = (busBeats > maxR) ? busBeats : maxR;
        end
        reqSeen = busReq;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t %s: got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    function automatic logic [31:0] pat(input logic [6:0] k);
        return {~{1'b0, k}, 8'h5a, {1'b0, k}, 8'hc3};
    endfunction : pat

    // Program the channel and start it
    task automatic go(input logic [31:0] s, d, n, si, di, m, c);
        wr(OFF_SRC_ADDR, s);
        wr(OFF_DST_ADDR, d);
        wr(OFF_COUNT, n);
        wr(OFF_SRC_INC, si);
        wr(OFF_DST_INC, di);
        wr(OFF_MASTER, m);
        bursts = 0;
        maxR = 0;
        maxW = 0;
        firstR = 0;
        holdSeen = 1'b0;
        wr(OFF_CTL, c | 32'h1);
    endtask : go

    task automatic t_regs;
        logic [31:0] q;
        logic e;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0, q, e);
            chk(q, RST_WORD, "value after reset");
            chk({31'h0, e}, 32'h0, "error on mapped register");
        end
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk({31'h0, e}, 32'h1, "unmapped access accepted");
        wr(OFF_SRC_ADDR, 32'h0001_0003);
        apb(1'b0, OFF_SRC_ADDR, 32'h0, q, e);
        chk(q, 32'h0001_0003, "descending address kept");
        $display("test registers done");
    endtask : t_regs

    task automatic t_copy(input string nm, input logic [31:0] s, d, si, di, m, c,
                          input int n, xr, xw, xf, input bit sl, held, rev);
        logic [31:0] st, x, sa, da;
        logic e;
        for (int i = 0; i < 128; i++) u_ddabe_bus_mem.mem[i] = pat(7'(i));
        slow <= sl;
        fifoHeldByOther <= held;
        go(s, d, 32'(n * 4), si, di, m, c);
        if (held) begin
            repeat (30) @(posedge sys_clk);
            chk(32'(bursts), 32'h0, "bus used while buffer held");
            fifoHeldByOther <= 1'b0;
        end
        st = 32'h0;
        for (int k = 0; k < 300 && st == 32'h0; k++) apb(1'b0, OFF_STATUS, 32'h0, st, e);
        chk(st, 32'h2, "status after copy");
        apb(1'b0, OFF_CTL, 32'h0, st, e);
        chk(st, c, "control after copy");
        for (int i = 0; i < n; i++) begin
            sa = (s & ~32'h3) + 32'(i) * si;
            da = (d & ~32'h3) + 32'(i) * di;
            x = pat(sa[8:2]);
            if (rev) x = {x[7:0], x[15:8], x[23:16], x[31:24]};
            chk(u_ddabe_bus_mem.mem[da[8:2]], x, "copied word");
        end
        if (xr != 0) chk(32'(maxR), 32'(xr), "largest read");
        if (xw != 0) chk(32'(maxW), 32'(xw), "largest write");
        if (xf != 0) chk(32'(firstR), 32'(xf), "first read");
        chk({31'h0, holdSeen}, {31'h0, held}, "buffer hold");
        wr(OFF_STATUS, 32'h3);
        $display("test %s done", nm);
    endtask : t_copy

    task automatic t_bad;
        logic [31:0] st;
        logic e;
        logic [31:0] sa [6] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
        logic [31:0] mc [6] = '{32'h1, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
        logic [31:0] xs [6] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h0, 32'h1};
        logic [31:0] cc [6] = '{32'(UNIT_16W) << CTL_UNIT_LO, 32'(UNIT_32W) << CTL_UNIT_LO,
                                C4B, C8 | RV, 32'h1 << CTL_SINGLE, C4W};
        for (int i = 0; i < 6; i++) begin
            go(sa[i], 32'h100, 32'h10, (i == 5) ? 32'h0 : 32'h4, 32'h4, mc[i], cc[i]);
            repeat (10) @(posedge sys_clk);
            apb(1'b0, OFF_STATUS, 32'h0, st, e);
            chk(st, xs[i], "status after bad setting");
            chk(32'(bursts), 32'h0, "bus used on bad setting");
            wr(OFF_STATUS, 32'h3);
        end
        $display("test bad settings done");
    endtask : t_bad

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_copy("mode one", 32'h54, 32'h11c, 4, 4, 1, C8 | SM, 16, 8, 8, 8, 0, 0, 0);
        t_copy("unequal", 32'h54, 32'h118, 4, 4, 1, C8, 16, 0, 0, 3, 1, 1, 0);
        t_copy("equal", 32'h54, 32'h154, 4, 4, 1, C8, 16, 8, 8, 3, 0, 0, 0);
        t_copy("src inh", 32'h0, 32'h100, 4, 4, 1, C8 | SM | SI, 16, 1, 8, 1, 0, 0, 0);
        t_copy("dst inh", 32'h0, 32'h100, 4, 8, 1, C8 | SM | DI, 8, 8, 1, 8, 0, 0, 0);
        t_copy("reverse", 32'h0, 32'h100, 4, 4, 0, C4B | RV, 4, 1, 1, 1, 0, 0, 1);
        t_copy("descend", 32'h1f, 32'h11f, -4, -4, 0, C4B, 4, 1, 1, 1, 0, 0, 0);
        t_copy("no buffer", 32'h20, 32'h100, 0, 4, 0, C4W | SI, 4, 1, 1, 1, 1, 0, 0);
        t_bad();
        complete_run();
    end
endmodule : tb

/* File: hdl/ddabe_engine.sv */
// One dual-address DMA channel: APB registers, legality check, burst planner
// and staging buffer. Assumes the internal bus acks one beat per busAck.
// What this block does
// [RULE1] Dual-address read-then-write when single select clear
// [RULE2] Illegal settings: flag error, no transfer
// [RULE3] Software aligns low address bits to increment sign
// [RULE4] Descending source keeps low two bits set
// [RULE5] Descending destination keeps low two bits set
// [RULE6] Sixteen or thirty-two word units are errors
// [RULE7] Eight-word staging buffer with byte shifter
// [RULE8] Bursts only for word units with buffer use
// [RULE9] Bursts split at 32-word address boundaries
// [RULE10] Size mode one: repeat full unit bursts
// [RULE11] Size mode zero equal offsets: align first
// [RULE12] Size mode zero unequal: read, then write to alignment
// [RULE13] Size mode zero unequal offsets lock buffer against other channels
// [RULE14] Source inhibit: single word reads
// [RULE15] Destination inhibit: single word writes
// [RULE16] Source increment limits without buffer use
// [RULE17] Destination increment limits without buffer use
// [RULE18] Inhibited side may step any multiple of four
// [RULE19] Reverse byte order of each word
// [RULE20] Software sets reverse only for word settings
// [RULE21] Check finishes before any bus cycle
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module ddabe_engine
    import ddabe_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Internal bus master
    output logic busReq,
    output logic busWrite,
    output logic [31:0] busAddr,
    output logic [2:0] busSize,
    output logic [3:0] busBeats,
    output logic [31:0] busWdata,
    input wire logic busAck,
    input wire logic [31:0] busRdata,
    // Buffer sharing with other channels
    input wire logic fifoHeldByOther,
    output logic fifoHold
);
    ddabe_state_e state;
    logic [31:0] srcAddr, dstAddr, byteCount, srcInc, dstInc, rdLeft;
    logic [CTL_WIDTH-1:0] chanCtl;
    logic fifoUse, cfgError, doneFlag;
    logic [3:0] fifoCount, beatsLeft;
    logic [FIFO_AW-1:0] head, tail;

    function automatic logic [5:0] min6(input logic [5:0] a, input logic [5:0] b);
        min6 = (a < b) ? a : b;
    endfunction : min6

    function automatic logic incOk(input logic [31:0] inc, input logic inh);
        incOk = (inc == INC_PLUS4) || (inc == INC_MINUS4) || (inh && inc[1:0] == 2'h0);
    endfunction : incOk

    function automatic logic [5:0] wordsLeft(input logic [31:0] bytes);
        wordsLeft = (|bytes[31:5]) ? 6'h08 : {3'h0, bytes[4:2]};
    endfunction : wordsLeft

    function automatic logic [31:0] rotBytes(input logic [31:0] d, input logic [1:0] n);
        unique case (n)
            2'h0: rotBytes = d;
            2'h1: rotBytes = {d[23:0], d[31:24]};
            2'h2: rotBytes = {d[15:0], d[31:16]};
            2'h3: rotBytes = {d[7:0], d[31:8]};
        endcase
    endfunction : rotBytes

    // Control fields
    wire [2:0] unitCode = chanCtl[CTL_UNIT_HI:CTL_UNIT_LO];
    wire ctlActive = chanCtl[CTL_ACTIVE];
    wire ctlSingle = chanCtl[CTL_SINGLE];
    wire sizeMode = chanCtl[CTL_SIZE_MODE];
    wire srcInh = chanCtl[CTL_SRC_INH];
    wire dstInh = chanCtl[CTL_DST_INH];
    wire reverse = chanCtl[CTL_REVERSE];
    wire wordUnit = (unitCode == UNIT_4W) || (unitCode == UNIT_8W);
    wire fifoMode = wordUnit && fifoUse;
    wire [2:0] itemBytes = (unitCode == UNIT_1B) ? 3'h1 : (unitCode == UNIT_2B) ? 3'h2 : 3'h4;
    wire [1:0] lowMask = ~(itemBytes[1:0] - 2'h1);
    wire [5:0] unitWords = (unitCode == UNIT_8W) ? 6'h08 : 6'h04;
    wire [2:0] offMask = (unitCode == UNIT_8W) ? 3'h7 : 3'h3;

    // Legality of the channel settings
    wire negS = srcInc[31];
    wire negD = dstInc[31];
    wire lowOk2 = (srcAddr[0] == negS) && (dstAddr[0] == negD) && !srcInc[0] && !dstInc[0]
        && !byteCount[0];
    wire lowOk4 = (srcAddr[1:0] == {2{negS}}) && (dstAddr[1:0] == {2{negD}}) // [RULE4] [RULE5]
        && (srcInc[1:0] == 2'h0) && (dstInc[1:0] == 2'h0) && (byteCount[1:0] == 2'h0);
    wire incsOk = incOk(srcInc, srcInh) && incOk(dstInc, dstInh);
    logic cfgLegal;
    always_comb begin
        unique case (unitCode)
            UNIT_1B: cfgLegal = !reverse;
            UNIT_2B: cfgLegal = lowOk2 && !reverse;
            UNIT_4B: cfgLegal = lowOk4;
            UNIT_4W, UNIT_8W: cfgLegal = lowOk4 && incsOk && !(fifoUse && reverse);
            default: cfgLegal = 1'b0; // [RULE6]
        endcase
    end

    // Burst planning: burst only when contiguous, buffered and not inhibited
    wire srcBurst = fifoMode && (srcInc == INC_PLUS4) && !srcInh; // [RULE8] [RULE14]
    wire dstBurst = fifoMode && (dstInc == INC_PLUS4) && !dstInh; // [RULE8] [RULE15]
    wire [2:0] sOff = srcAddr[4:2] & offMask;
    wire [2:0] dOff = dstAddr[4:2] & offMask;
    wire [5:0] sBound = BOUNDARY_WORDS - {1'b0, srcAddr[6:2]}; // [RULE9]
    wire [5:0] dBound = BOUNDARY_WORDS - {1'b0, dstAddr[6:2]}; // [RULE9]
    wire [5:0] sAlign = sizeMode ? unitWords : unitWords - {3'h0, sOff}; // [RULE10] [RULE11]
    wire [5:0] dAlign = sizeMode ? unitWords : unitWords - {3'h0, dOff}; // [RULE10] [RULE12]
    wire [5:0] freeSlots = 6'(DEPTH) - {2'h0, fifoCount};
    wire [5:0] rdLen = srcBurst ? min6(min6(min6(wordsLeft(rdLeft), unitWords), sBound),
        min6(freeSlots, sAlign)) : 6'h01; // [RULE12]
    wire [5:0] wrWant = dstBurst ? min6(min6(wordsLeft(byteCount), unitWords),
        min6(dBound, dAlign)) : 6'h01;
    wire [5:0] wrLen = sizeMode ? wrWant : min6(wrWant, {2'h0, fifoCount});
    wire doWrite = (sizeMode && dstBurst) ? ({2'h0, fifoCount} >= wrWant) // [RULE10]
        : (fifoCount != 4'h0); // [RULE11] [RULE12]
    wire needsLock = fifoMode && !sizeMode && (sOff != dOff); // [RULE13]

    // Beat events and the byte shifter feeding the buffer
    wire pushEn = (state == ST_READ) && busAck;
    wire popEn = (state == ST_WRITE) && busAck;
    wire [31:0] swapped = {busRdata[7:0], busRdata[15:8], busRdata[23:16], busRdata[31:24]};
    wire [1:0] rot = (dstAddr[1:0] & lowMask) - (srcAddr[1:0] & lowMask);
    wire [31:0] pushData = rotBytes(reverse ? swapped : busRdata, rot); // [RULE7] [RULE19]
    wire [FIFO_AW-1:0] rdAddr = popEn ? head + 3'h1 : head;

    // Check outcome
    wire checkBad = (state == ST_CHECK) && (ctlSingle || !cfgLegal); // [RULE1]
    wire setCfgErr = (state == ST_CHECK) && !ctlSingle && !cfgLegal; // [RULE2]
    wire finish = (state == ST_PLAN) && (byteCount == 32'h0);
    wire checkGo = (state == ST_CHECK) && !checkBad && !(needsLock && fifoHeldByOther);

    // APB decode
    wire apbSetup = psel && !penable;
    wire apbDone = psel && penable && pready;
    wire idle = (state == ST_IDLE);
    wire mapped = (paddr[1:0] == 2'h0) && (paddr <= OFF_MASTER);
    wire wrEn = apbDone && pwrite && mapped;
    wire cfgWr = wrEn && idle;
    wire stsWr = wrEn && (paddr == OFF_STATUS);
    logic [31:0] rdMux;
    always_comb begin
        unique case (paddr)
            OFF_SRC_ADDR: rdMux = srcAddr;
            OFF_DST_ADDR: rdMux = dstAddr;
            OFF_COUNT: rdMux = byteCount;
            OFF_SRC_INC: rdMux = srcInc;
            OFF_DST_INC: rdMux = dstInc;
            OFF_CTL: rdMux = {23'h0, chanCtl};
            OFF_STATUS: rdMux = {30'h0, doneFlag, cfgError};
            OFF_MASTER: rdMux = {31'h0, fifoUse};
            default: rdMux = 32'h0;
        endcase
    end

    // APB answer: no wait states, read data sampled in setup
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RST_WORD;
        end else begin
            pready <= apbSetup;
            pslverr <= apbSetup && !mapped;
            prdata <= (apbSetup && !pwrite) ? rdMux : prdata;
        end
    end

    // Channel registers; software writes only while idle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            srcAddr <= RST_WORD;
            dstAddr <= RST_WORD;
            byteCount <= RST_WORD;
            srcInc <= RST_WORD;
            dstInc <= RST_WORD;
            chanCtl <= RST_CTL;
            fifoUse <= 1'b0;
        end else begin
            if (cfgWr && paddr == OFF_SRC_ADDR) srcAddr <= pwdata;
            else if (pushEn) srcAddr <= srcAddr + srcInc;
            if (cfgWr && paddr == OFF_DST_ADDR) dstAddr <= pwdata;
            else if (popEn) dstAddr <= dstAddr + dstInc;
            if (cfgWr && paddr == OFF_COUNT) byteCount <= pwdata;
            else if (popEn) byteCount <= byteCount - {29'h0, itemBytes};
            if (cfgWr && paddr == OFF_SRC_INC) srcInc <= pwdata;
            if (cfgWr && paddr == OFF_DST_INC) dstInc <= pwdata;
            if (cfgWr && paddr == OFF_MASTER) fifoUse <= pwdata[MST_FIFO_USE];
            if (cfgWr && paddr == OFF_CTL) chanCtl <= pwdata[CTL_WIDTH-1:0];
            else if (checkBad || finish) chanCtl[CTL_ACTIVE] <= 1'b0; // [RULE2]
        end
    end

    // Sticky status, write one to clear, setting wins
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfgError <= 1'b0;
            doneFlag <= 1'b0;
        end else begin
            cfgError <= setCfgErr || (cfgError && !(stsWr && pwdata[STS_CFG_ERR])); // [RULE2]
            doneFlag <= finish || (doneFlag && !(stsWr && pwdata[STS_DONE]));
        end
    end

    // Buffer occupancy and pointers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            head <= '0;
            tail <= '0;
            fifoCount <= 4'h0;
        end else begin
            if (pushEn) tail <= tail + 3'h1;
            if (popEn) head <= head + 3'h1;
            fifoCount <= fifoCount + {3'h0, pushEn} - {3'h0, popEn};
        end
    end

    // Engine: check, plan each burst, run beats
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            busReq <= 1'b0;
            busWrite <= 1'b0;
            busAddr <= RST_WORD;
            busSize <= 3'h4;
            busBeats <= 4'h0;
            beatsLeft <= 4'h0;
            rdLeft <= RST_WORD;
            fifoHold <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (ctlActive) state <= ST_CHECK;
                end
                ST_CHECK: begin
                    if (checkBad) begin
                        state <= ST_IDLE; // [RULE21]
                    end else if (checkGo) begin
                        state <= ST_PLAN;
                        fifoHold <= needsLock; // [RULE13]
                        rdLeft <= byteCount;
                    end
                end
                ST_PLAN: begin
                    busSize <= itemBytes;
                    if (finish) begin
                        state <= ST_IDLE;
                        fifoHold <= 1'b0;
                    end else if (doWrite) begin
                        state <= ST_WRITE;
                        busReq <= 1'b1;
                        busWrite <= 1'b1;
                        busAddr <= {dstAddr[31:2], dstAddr[1:0] & lowMask};
                        busBeats <= wrLen[3:0];
                        beatsLeft <= wrLen[3:0];
                    end else begin
                        state <= ST_READ; // [RULE1]
                        busReq <= 1'b1;
                        busWrite <= 1'b0;
                        busAddr <= {srcAddr[31:2], srcAddr[1:0] & lowMask};
                        busBeats <= rdLen[3:0];
                        beatsLeft <= rdLen[3:0];
                    end
                end
                ST_READ, ST_WRITE: begin
                    if (busAck) begin
                        beatsLeft <= beatsLeft - 4'h1;
                        if (state == ST_READ) rdLeft <= rdLeft - {29'h0, itemBytes};
                        if (beatsLeft == 4'h1) begin
                            busReq <= 1'b0;
                            state <= ST_PLAN;
                        end
                    end
                end
            endcase
        end
    end

    // Staging buffer storage; write data leaves straight from its register
    ddabe_fifo_mem #(.WIDTH(32), .DEPTH(DEPTH), .AW(FIFO_AW)) u_mem (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .wrEn(pushEn),
        .wrAddr(tail),
        .wrData(pushData),
        .rdAddr(rdAddr),
        .rdData(busWdata)
    );

    // Checks on the engine's own behaviour
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_cfg_error_stop: assert property (setCfgErr |=> cfgError && !busReq && !ctlActive ##1 !busReq) // [RULE2]
        else $error("bad settings did not stop the channel");
    a_big_unit_err: assert property ((state == ST_CHECK) && !ctlSingle && (unitCode == UNIT_16W || unitCode == UNIT_32W) |=> cfgError) // [RULE6]
        else $error("oversized unit accepted");
    a_check_first: assert property ($rose(busReq) |-> $past(cfgLegal) && !$past(ctlSingle)) // [RULE21]
        else $error("bus cycle without passing the check");
    a_write_after_read: assert property ($rose(busReq) && busWrite |-> fifoCount != 4'h0) // [RULE1]
        else $error("write issued with nothing read");
    a_burst_when_fifo: assert property (busReq && busBeats > 4'h1 |-> fifoMode) // [RULE8]
        else $error("burst outside buffered word mode");
    a_no_boundary_cross: assert property (busReq && busBeats > 4'h1 |-> ({1'b0, busAddr[6:2]} + {2'h0, busBeats}) <= BOUNDARY_WORDS) // [RULE9]
        else $error("burst crosses 32-word boundary");
    a_src_inhibit_single: assert property (busReq && !busWrite && srcInh |-> busBeats == 4'h1) // [RULE14]
        else $error("inhibited source used a burst");
    a_dst_inhibit_single: assert property (busReq && busWrite && dstInh |-> busBeats == 4'h1) // [RULE15]
        else $error("inhibited destination used a burst");
    a_mode0_align: assert property ($rose(busReq) && !sizeMode && busBeats > 4'h1 |-> ({3'h0, busAddr[4:2] & offMask} + {2'h0, busBeats}) <= unitWords) // [RULE11]
        else $error("burst passes the aligned address");
    a_fifo_bound: assert property (fifoCount <= 4'(DEPTH) && !(pushEn && fifoCount == 4'(DEPTH))) // [RULE7]
        else $error("staging buffer overflow");
    a_lock_respected: assert property ((state == ST_CHECK) ##1 (state == ST_PLAN) && fifoHold |-> !$past(fifoHeldByOther)) // [RULE13]
        else $error("buffer taken while held elsewhere");
    a_byte_reverse: assert property (pushEn && reverse && rot == 2'h0 |-> pushData[7:0] == busRdata[31:24] && pushData[31:24] == busRdata[7:0]) // [RULE19]
        else $error("word not byte reversed");

    c_config_error: cover property (setCfgErr);
    c_full_burst: cover property (busReq && busWrite && busBeats == 4'h8);
    c_split_burst: cover property ($rose(busReq) && busBeats > 4'h1 && ({1'b0, busAddr[6:2]} + {2'h0, busBeats}) == BOUNDARY_WORDS);
    c_lock_wait: cover property ((state == ST_CHECK) && needsLock && fifoHeldByOther);
endmodule : ddabe_engine

/* File: hdl/ddabe_fifo_mem.sv */
// Word storage of the channel's staging buffer, one write and one read port.
// Read data comes out of a register one edge after the read address.
`timescale 1ns/1ps
module ddabe_fifo_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // Read port
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Storage array, no reset needed
    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // Registered read
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdData <= '0;
        end else begin
            rdData <= mem[rdAddr];
        end
    end
endmodule : ddabe_fifo_mem

/* File: hdl/ddabe_pkg.sv */
// Constants for the dual-address burst DMA channel: register map,
// field positions, reset values, unit-size codes and engine states.
// Assumes a 32-bit APB register port and a word-wide internal bus.
package ddabe_pkg;

    // Register byte offsets on APB
    localparam logic [7:0] OFF_SRC_ADDR = 8'h00;
    localparam logic [7:0] OFF_DST_ADDR = 8'h04;
    localparam logic [7:0] OFF_COUNT = 8'h08;
    localparam logic [7:0] OFF_SRC_INC = 8'h0c;
    localparam logic [7:0] OFF_DST_INC = 8'h10;
    localparam logic [7:0] OFF_CTL = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_MASTER = 8'h1c;

    // Channel control field positions
    localparam int CTL_ACTIVE = 0;
    localparam int CTL_SINGLE = 1;
    localparam int CTL_UNIT_LO = 2;
    localparam int CTL_UNIT_HI = 4;
    localparam int CTL_SIZE_MODE = 5;
    localparam int CTL_SRC_INH = 6;
    localparam int CTL_DST_INH = 7;
    localparam int CTL_REVERSE = 8;
    localparam int CTL_WIDTH = 9;

    // Status and master control field positions
    localparam int STS_CFG_ERR = 0;
    localparam int STS_DONE = 1;
    localparam int MST_FIFO_USE = 0;

    // Values after reset
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [CTL_WIDTH-1:0] RST_CTL = 9'h000;

    // Unit-size codes in the control register
    localparam logic [2:0] UNIT_1B = 3'h0;
    localparam logic [2:0] UNIT_2B = 3'h1;
    localparam logic [2:0] UNIT_4B = 3'h2;
    localparam logic [2:0] UNIT_4W = 3'h3;
    localparam logic [2:0] UNIT_8W = 3'h4;
    localparam logic [2:0] UNIT_16W = 3'h5;
    localparam logic [2:0] UNIT_32W = 3'h6;

    // Staging buffer and burst geometry
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW = 3;
    localparam logic [5:0] BOUNDARY_WORDS = 6'h20;
    localparam logic [31:0] INC_PLUS4 = 32'h0000_0004;
    localparam logic [31:0] INC_MINUS4 = 32'hffff_fffc;

    // Engine states
    typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_PLAN, ST_READ, ST_WRITE} ddabe_state_e;

endpackage : ddabe_pkg
